/* dds_core_clock_config.sv */
// Phase accumulator synthesizer with serial configuration and clock control
`timescale 1ns/1ps
`default_nettype none
// How it works
// - 32-bit accumulator advanced by tuning word
// - Words above half wrap, giving alias frequency
// - Phase mapped through cosine to 14-bit sample
// - Offset word added at top of phase
// - Zero tuning word holds, zero offset runs
// - Bits 13 and 8 force accumulator zero
// - Clear active at power-up until first update
// - Multiplier 4 to 20 drives the PLL
// - Out of range multiplier bypasses, powers down
// - Select pin enables oscillator and gates buffer
// - Bit 4 stops synth clock, oscillator runs
// - Bit 9 enables crystal output buffer
// - Multiplier independent of clock stop bit
// - Bit 6 powers down the comparator
// - Serial port reads and writes every register
// - MSB-first or LSB-first bit order
// - Two-wire shared pin or three-wire split
// - Abort and chip select are optional
// - Abort kills transfer until released
// - Unselected device ignores serial traffic
module dds_core_clock_config
  import dds_core_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // Serial port pins
  input wire logic i_serial_clock,
  input wire logic i_cs_b,
  input wire logic i_serial_port_abort,
  input wire logic i_sdio,
  output logic o_sdio,
  output logic o_sdio_oe,
  output logic o_serial_data_output,
  input wire logic i_io_update,
  // Port format
  input wire logic i_lsb_first,
  input wire logic i_three_wire,
  // Clock source
  input wire logic i_clock_source_select_pin,
  output logic o_osc_enable,
  output logic o_xtal_out_enable,
  output logic o_synth_clock_stop,
  output logic [4:0] o_pll_multiplier,
  output logic o_pll_enable,
  output logic o_pll_bypass,
  // Analog control and sample
  output logic o_comparator_power_down,
  output logic [DAC_W-1:0] o_dac_sample
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  localparam int NS = 6;
  // Chip select idles high: its chain starts deselected, not selected
  localparam logic [NS-1:0] SYNC_IDLE = 6'h04;
  logic [NS-1:0] pins_raw, sync1, sync2;
  logic sclk_q, upd_q;
  assign pins_raw = {i_clock_source_select_pin, i_io_update, i_serial_port_abort,
                     i_cs_b, i_sdio, i_serial_clock};
  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++)
    begin : g_sync
      always_ff @(posedge i_sys_clk or negedge i_rst_b)
      begin
        if (!i_rst_b)
          {sync2[gi], sync1[gi]} <= {2{SYNC_IDLE[gi]}};
        else
          {sync2[gi], sync1[gi]} <= {sync1[gi], pins_raw[gi]};
      end
    end
  endgenerate
  logic sclk, sdi, cs_b, abort, upd, osc_sel;
  assign {osc_sel, upd, abort, cs_b, sdi, sclk} = sync2;
  logic sclk_rise, sclk_fall, upd_rise;
  assign sclk_rise = sclk & ~sclk_q;
  assign sclk_fall = ~sclk & sclk_q;
  assign upd_rise = upd & ~upd_q;
  // ----------------------------------------
  // Serial port and register file
  // ----------------------------------------
  sp_state_t st, next_st;
  logic [5:0] bit_cnt, next_cnt;
  logic [31:0] sr, next_sr;
  logic rd, next_rd;
  logic [4:0] addr, next_addr;
  logic out_bit, next_out;
  logic [31:0] cr1_buf, next_cr1_buf, cr1, next_cr1;
  logic [23:0] cr2_buf, next_cr2_buf, cr2, next_cr2;
  logic [31:0] ftw_buf, next_ftw_buf, frequency_tuning_word, next_ftw;
  logic [15:0] pow_buf, next_pow_buf, phase_offset_word, next_pow;
  function automatic logic [5:0] reg_bits(input logic [4:0] a);
    unique case (a)
      ADDR_CR1: reg_bits = CR1_BITS;
      ADDR_CR2: reg_bits = CR2_BITS;
      ADDR_FTW: reg_bits = FTW_BITS;
      ADDR_POW: reg_bits = POW_BITS;
      default: reg_bits = OTHER_BITS;
    endcase
  endfunction : reg_bits
  logic [5:0] nbits;
  logic [31:0] rd_word, wr_word;
  logic [7:0] instr;
  logic [5:0] rd_idx;
  assign nbits = reg_bits(addr);
  // Reads return the buffered copy, which is what the host last wrote
  always_comb
  begin
    unique case (addr)
      ADDR_CR1: rd_word = cr1_buf;
      ADDR_CR2: rd_word = {8'h00, cr2_buf};
      ADDR_FTW: rd_word = ftw_buf;
      ADDR_POW: rd_word = {16'h0000, pow_buf};
      default: rd_word = 32'h0000_0000;
    endcase
  end
  always_comb
  begin
    next_st = st;
    next_cnt = bit_cnt;
    next_sr = sr;
    next_rd = rd;
    next_addr = addr;
    next_out = out_bit;
    next_cr1_buf = cr1_buf;
    next_cr2_buf = cr2_buf;
    next_ftw_buf = ftw_buf;
    next_pow_buf = pow_buf;
    next_cr1 = cr1;
    next_cr2 = cr2;
    next_ftw = frequency_tuning_word;
    next_pow = phase_offset_word;
    next_sr = i_lsb_first ? {sdi, sr[31:1]} : {sr[30:0], sdi};
    instr = i_lsb_first ? next_sr[31:24] : next_sr[7:0];
    wr_word = i_lsb_first ? (next_sr >> (6'h20 - nbits)) : next_sr;
    rd_idx = i_lsb_first ? bit_cnt : nbits - 6'h01 - bit_cnt;
    if (abort || cs_b)
    begin
      next_sr = sr;
      next_st = ST_INSTR;
      next_cnt = 6'h00;
    end
    else if (sclk_rise)
    begin
      next_cnt = bit_cnt + 6'h01;
      if (st == ST_INSTR)
      begin
        if (bit_cnt == INSTR_LAST)
        begin
          next_rd = instr[INSTR_RD];
          next_addr = instr[4:0];
          next_st = ST_DATA;
          next_cnt = 6'h00;
        end
      end
      else if (bit_cnt == nbits - 6'h01)
      begin
        if (!rd)
        begin
          unique case (addr)
            ADDR_CR1: next_cr1_buf = wr_word;
            ADDR_CR2: next_cr2_buf = wr_word[23:0];
            ADDR_FTW: next_ftw_buf = wr_word;
            ADDR_POW: next_pow_buf = wr_word[15:0];
            default: next_cr1_buf = cr1_buf;
          endcase
        end
        next_st = ST_INSTR;
        next_cnt = 6'h00;
      end
    end
    else
    begin
      next_sr = sr;
      if (sclk_fall && st == ST_DATA && rd)
        next_out = rd_word[rd_idx[4:0]];
    end
    // Commit strobe copies buffers into the active set
    if (upd_rise)
    begin
      next_cr1 = cr1_buf;
      next_cr2 = cr2_buf;
      next_ftw = ftw_buf;
      next_pow = pow_buf;
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      st <= ST_INSTR;
      bit_cnt <= 6'h00;
      sr <= 32'h0000_0000;
      rd <= 1'b0;
      addr <= 5'h00;
      out_bit <= 1'b0;
      sclk_q <= 1'b0;
      upd_q <= 1'b0;
      cr1_buf <= CR1_RST_BUF;
      cr1 <= CR1_RST_ACT;
      cr2_buf <= CR2_RST;
      cr2 <= CR2_RST;
      ftw_buf <= FTW_RST;
      frequency_tuning_word <= FTW_RST;
      pow_buf <= POW_RST;
      phase_offset_word <= POW_RST;
    end
    else
    begin
      st <= next_st;
      bit_cnt <= next_cnt;
      sr <= next_sr;
      rd <= next_rd;
      addr <= next_addr;
      out_bit <= next_out;
      sclk_q <= sclk;
      upd_q <= upd;
      cr1_buf <= next_cr1_buf;
      cr1 <= next_cr1;
      cr2_buf <= next_cr2_buf;
      cr2 <= next_cr2;
      ftw_buf <= next_ftw_buf;
      frequency_tuning_word <= next_ftw;
      pow_buf <= next_pow_buf;
      phase_offset_word <= next_pow;
    end
  end
  // Shared pin is driven only in two-wire mode while read data flows
  assign o_sdio = out_bit;
  assign o_sdio_oe = ~i_three_wire & rd & (st == ST_DATA) & ~cs_b & ~abort;
  assign o_serial_data_output = out_bit;
  // ----------------------------------------
  // Clock configuration
  // ----------------------------------------
  logic [4:0] mult;
  assign mult = cr2[CR2_MULT_HI:CR2_MULT_LO];
  assign o_pll_multiplier = mult;
  assign o_pll_enable = (mult >= MULT_MIN) && (mult <= MULT_MAX);
  assign o_pll_bypass = ~o_pll_enable;
  assign o_osc_enable = osc_sel;
  assign o_xtal_out_enable = osc_sel & cr2[CR2_XTAL_OUT];
  assign o_synth_clock_stop = cr1[CR1_CLK_STOP];
  assign o_comparator_power_down = cr1[CR1_COMP_PD];
  // ----------------------------------------
  // Accumulator and cosine mapping
  // ----------------------------------------
  logic [ACC_W-1:0] acc, next_acc;
  logic [DAC_W-1:0] next_dac;
  logic clr;
  logic [ACC_W-1:0] phase;
  logic [13:0] t, hc;
  logic [26:0] prod;
  logic [14:0] y, pos;
  assign clr = cr1[CR1_CLR] | cr1[CR1_CLR_AUTO];
  assign phase = acc + {phase_offset_word[POW_W-1:0], {POW_SHIFT{1'b0}}};
  // Parabolic cosine: cheaper than a table, a few percent of harmonic error
  always_comb
  begin
    if (clr)
      next_acc = '0;
    else if (o_synth_clock_stop)
      next_acc = acc;
    else
      next_acc = acc + frequency_tuning_word;
    t = phase[ACC_W-1:POW_SHIFT] + QUARTER;
    hc = HALF - {1'b0, t[12:0]};
    prod = t[12:0] * hc;
    y = {1'b0, prod[24:11]};
    pos = MID + y;
    next_dac = t[13] ? 14'(MID - y) : ((pos > FULL) ? 14'h3fff : pos[13:0]);
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      acc <= '0;
      o_dac_sample <= 14'h0000;
    end
    else
    begin
      acc <= next_acc;
      o_dac_sample <= next_dac;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic seen_upd;
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      seen_upd <= 1'b0;
    else
      seen_upd <= seen_upd | upd_rise;
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  acc_step_a: assert property (!clr && !o_synth_clock_stop |=> acc == $past(acc) + $past(frequency_tuning_word))
    else $error("accumulator did not advance by tuning word");
  acc_clear_a: assert property (clr |=> acc == '0) else $error("accumulator not cleared");
  clock_stop_a: assert property (o_synth_clock_stop && !clr |=> $stable(acc))
    else $error("accumulator moved while clock stopped");
  zero_word_a: assert property (frequency_tuning_word == '0 && !clr ##1 frequency_tuning_word == '0 && !clr |=> $stable(acc))
    else $error("accumulator moved with zero tuning word");
  powerup_clear_a: assert property (!seen_upd |-> acc == '0)
    else $error("accumulator ran before first update");
  commit_copy_a: assert property (upd_rise |=> frequency_tuning_word == $past(ftw_buf) && cr1 == $past(cr1_buf))
    else $error("update did not copy buffers");
  cos_peak_a: assert property (phase == '0 |=> o_dac_sample == 14'h3fff)
    else $error("cosine peak wrong at zero phase");
  pll_top_a: assert property (mult == MULT_MAX |-> o_pll_enable && !o_pll_bypass)
    else $error("PLL not enabled at top multiplier");
  pll_low_a: assert property (mult == 5'h03 |-> o_pll_bypass && !o_pll_enable)
    else $error("PLL not bypassed below range");
  xtal_buf_a: assert property (o_xtal_out_enable |-> o_osc_enable && cr2[CR2_XTAL_OUT])
    else $error("crystal buffer on without its enables");
  abort_a: assert property (abort |=> st == ST_INSTR && bit_cnt == 6'h00)
    else $error("transfer survived abort");
  unsel_a: assert property (cs_b |=> $stable(ftw_buf) && $stable(cr1_buf))
    else $error("register written while unselected");
  upd_c: cover property (upd_rise ##1 !clr);
  read_c: cover property (st == ST_DATA && rd && sclk_fall);
  pll_c: cover property (o_pll_enable);
  abort_c: cover property (st == ST_DATA && abort);
endmodule : dds_core_clock_config
`default_nettype wire

/* dds_core_pkg.sv */
// Constants and types shared by the synthesizer core
package dds_core_pkg;
  localparam int ACC_W = 32;
  localparam int POW_W = 14;
  localparam int DAC_W = 14;
  localparam int POW_SHIFT = ACC_W - POW_W;
  // Serial addresses
  localparam logic [4:0] ADDR_CR1 = 5'h00;
  localparam logic [4:0] ADDR_CR2 = 5'h01;
  localparam logic [4:0] ADDR_FTW = 5'h04;
  localparam logic [4:0] ADDR_POW = 5'h05;
  // Register widths in bits
  localparam logic [5:0] CR1_BITS = 6'h20;
  localparam logic [5:0] CR2_BITS = 6'h18;
  localparam logic [5:0] FTW_BITS = 6'h20;
  localparam logic [5:0] POW_BITS = 6'h10;
  localparam logic [5:0] OTHER_BITS = 6'h08;
  // Field positions
  localparam int CR1_CLR_AUTO = 13;
  localparam int CR1_CLR = 8;
  localparam int CR1_COMP_PD = 6;
  localparam int CR1_CLK_STOP = 4;
  localparam int CR2_XTAL_OUT = 9;
  localparam int CR2_MULT_HI = 7;
  localparam int CR2_MULT_LO = 3;
  localparam int INSTR_RD = 7;
  localparam logic [5:0] INSTR_LAST = 6'h07;
  // Multiplier range
  localparam logic [4:0] MULT_MIN = 5'h04;
  localparam logic [4:0] MULT_MAX = 5'h14;
  // Values after reset
  localparam logic [31:0] CR1_RST_ACT = 32'h0000_0100;
  localparam logic [31:0] CR1_RST_BUF = 32'h0000_0000;
  localparam logic [23:0] CR2_RST = 24'h18_0000;
  localparam logic [31:0] FTW_RST = 32'h0000_0000;
  localparam logic [15:0] POW_RST = 16'h0000;
  // Cosine approximation
  localparam logic [13:0] QUARTER = 14'h1000;
  localparam logic [13:0] HALF = 14'h2000;
  localparam logic [14:0] MID = 15'h2000;
  localparam logic [14:0] FULL = 15'h3fff;
  typedef enum {ST_INSTR, ST_DATA} sp_state_t;
endpackage : dds_core_pkg

/* dds_host_model.sv */
// Host serial master model driving the synthesizer core's serial pins
`timescale 1ns/1ps
`default_nettype none
module dds_host_model
(
  // Clock
  input wire logic i_sys_clk,
  // Port format
  input wire logic i_lsb_first,
  input wire logic i_three_wire,
  // Serial pins
  output logic o_serial_clock,
  output logic o_cs_b,
  output logic o_abort,
  output logic o_sdio,
  output logic o_io_update,
  input wire logic i_sdio,
  input wire logic i_sdo
);
  // --------------------------------
  // Bit timing
  // --------------------------------
  // Each serial level lasts well over the two sys clocks the synchronizer needs
  localparam int HALF_BIT = 5;

  initial
  begin
    o_serial_clock = 1'b0;
    o_cs_b = 1'b1;
    o_abort = 1'b0;
    o_sdio = 1'b0;
    o_io_update = 1'b0;
  end

  task tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask : tick

  // Released data line shows the inverse of the last bit, never a stale copy
  task shift(input logic [31:0] v, input int n, input logic rd, output logic [31:0] q);
    int k;
    q = '0;
    for (int i = 0; i < n; i++)
    begin
      k = i_lsb_first ? i : n - 1 - i;
      o_sdio = rd ? ~o_sdio : v[k];
      tick(HALF_BIT);
      q[k] = i_three_wire ? i_sdo : i_sdio;
      o_serial_clock = 1'b1;
      tick(HALF_BIT);
      o_serial_clock = 1'b0;
    end
  endtask : shift

  task select(input logic sel);
    o_cs_b = ~sel;
    tick(HALF_BIT);
  endtask : select

  task frame(input logic rd, input logic [4:0] a, input logic [31:0] v, input int n,
             output logic [31:0] q);
    logic [31:0] d;
    select(1'b1);
    shift({24'h0, rd, 2'b00, a}, 8, 1'b0, d);
    shift(v, n, rd, q);
    select(1'b0);
  endtask : frame

  task commit();
    o_io_update = 1'b1;
    tick(4);
    o_io_update = 1'b0;
    tick(4);
  endtask : commit

  task abort_now();
    o_abort = 1'b1;
    tick(4);
    o_abort = 1'b0;
    tick(4);
  endtask : abort_now
endmodule : dds_host_model
`default_nettype wire

/* dds_core_clock_config_tb.sv */
// Self-checking testbench for the synthesizer core
`timescale 1ns/1ps
`default_nettype none
module dds_core_clock_config_tb;
  import dds_core_pkg::*;
  logic sys_clk, rst_b, sclk, cs_b, abort, host_sdio, dut_sdio, sdio_oe, serial_data_output, io_update;
  logic lsb_first, three_wire, sel_pin, osc_en, xtal_en, clk_stop, pll_en, pll_byp, comp_pd;
  logic [4:0] mult;
  logic [DAC_W-1:0] dac, d;
  logic [31:0] q;
  int bad_count, cmp_count;
  wire logic sdio_wire = sdio_oe ? dut_sdio : host_sdio;
  logic [13:0] seq [5] = '{14'h3fff, 14'h2000, 14'h0000, 14'h2000, 14'h3fff};
  logic [31:0] ftws [2] = '{32'h4000_0000, 32'hc000_0000};
  logic [4:0] mults [5] = '{5'h03, 5'h04, 5'h14, 5'h15, 5'h1f};
  int bits [2] = '{CR1_CLR, CR1_CLR_AUTO};

  dds_core_clock_config i_dut (.i_sys_clk(sys_clk), .i_rst_b(rst_b), .i_serial_clock(sclk),
    .i_cs_b(cs_b), .i_serial_port_abort(abort), .i_sdio(sdio_wire), .o_sdio(dut_sdio),
    .o_sdio_oe(sdio_oe), .o_serial_data_output(serial_data_output), .i_io_update(io_update),
    .i_lsb_first(lsb_first), .i_three_wire(three_wire), .i_clock_source_select_pin(sel_pin),
    .o_osc_enable(osc_en), .o_xtal_out_enable(xtal_en), .o_synth_clock_stop(clk_stop),
    .o_pll_multiplier(mult), .o_pll_enable(pll_en), .o_pll_bypass(pll_byp),
    .o_comparator_power_down(comp_pd), .o_dac_sample(dac));
  dds_host_model i_host (.i_sys_clk(sys_clk), .i_lsb_first(lsb_first),
    .i_three_wire(three_wire), .o_serial_clock(sclk), .o_cs_b(cs_b), .o_abort(abort),
    .o_sdio(host_sdio), .o_io_update(io_update), .i_sdio(sdio_wire), .i_sdo(serial_data_output));

  // --------------------------------
  // Helpers
  // --------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [4:0] a, input logic [31:0] v, input int n);
    i_host.frame(1'b0, a, v, n, q);
  endtask : wr

  task rd_chk(input logic [4:0] a, input int n, input logic [31:0] exp);
    i_host.frame(1'b1, a, 32'h0, n, q);
    chk(q, exp);
  endtask : rd_chk

  task end_sim();
    if (bad_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  initial
  begin
    repeat (60000) @(posedge sys_clk);
    bad_count++;
    end_sim();
  end

  // --------------------------------
  // Tests
  // --------------------------------
  initial
  begin
    rst_b = 1'b0;
    lsb_first = 1'b0;
    three_wire = 1'b0;
    sel_pin = 1'b1;
    repeat (8) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    i_host.tick(3);
    chk({pll_byp, pll_en, clk_stop, comp_pd, xtal_en, mult}, 10'h200);
    chk(osc_en, 1'b1);
    rd_chk(ADDR_CR2, CR2_BITS, CR2_RST);
    rd_chk(ADDR_CR1, CR1_BITS, CR1_RST_BUF);
    wr(ADDR_FTW, ftws[0], FTW_BITS);
    for (int i = 0; i < 10; i++)
    begin
      chk(dac, 14'h3fff);
      i_host.tick(1);
    end
    for (int f = 0; f < 2; f++)
    begin
      wr(ADDR_FTW, ftws[f], FTW_BITS);
      i_host.commit();
      for (int i = 0; i < 8 && dac !== 14'h3fff; i++) i_host.tick(1);
      for (int i = 0; i < 5; i++)
      begin
        chk(dac, seq[i]);
        i_host.tick(1);
      end
    end
    wr(ADDR_FTW, 32'h0, FTW_BITS);
    i_host.commit();
    d = dac;
    i_host.tick(10);
    chk(dac, d);
    wr(ADDR_FTW, ftws[0], FTW_BITS);
    for (int b = 0; b < 2; b++)
    begin
      wr(ADDR_CR1, 32'h1 << bits[b], CR1_BITS);
      i_host.commit();
      chk(dac, 14'h3fff);
      i_host.tick(3);
      chk(dac, 14'h3fff);
      wr(ADDR_POW, 16'h2000, POW_BITS);
      i_host.commit();
      chk(dac, 14'h0000);
      wr(ADDR_POW, 16'h1000, POW_BITS);
      i_host.commit();
      chk(dac, 14'h2000);
      wr(ADDR_POW, 16'h0, POW_BITS);
      wr(ADDR_CR1, 32'h0, CR1_BITS);
      i_host.commit();
    end
    wr(ADDR_CR1, (32'h1 << CR1_CLK_STOP) | (32'h1 << CR1_COMP_PD), CR1_BITS);
    i_host.commit();
    chk({clk_stop, comp_pd}, 2'b11);
    d = dac;
    i_host.tick(3);
    chk(dac, d);
    wr(ADDR_CR2, (24'h0a << CR2_MULT_LO) | (24'h1 << CR2_XTAL_OUT), CR2_BITS);
    i_host.commit();
    i_host.tick(10000);
    chk({pll_en, mult, xtal_en}, 7'h55);
    sel_pin = 1'b0;
    i_host.tick(3);
    chk({osc_en, xtal_en}, 2'b00);
    sel_pin = 1'b1;
    for (int m = 0; m < 5; m++)
    begin
      wr(ADDR_CR2, {16'h0, mults[m], 3'b000}, CR2_BITS);
      i_host.commit();
      chk({pll_en, pll_byp, mult}, {mults[m] >= MULT_MIN && mults[m] <= MULT_MAX,
          mults[m] < MULT_MIN || mults[m] > MULT_MAX, mults[m]});
    end
    for (int f = 0; f < 4; f++)
    begin
      lsb_first = f[0];
      three_wire = f[1];
      i_host.tick(1);
      wr(ADDR_FTW, 32'h8c3a_51e6 + f, FTW_BITS);
      rd_chk(ADDR_FTW, FTW_BITS, 32'h8c3a_51e6 + f);
    end
    wr(5'h07, 32'ha5, OTHER_BITS);
    rd_chk(5'h07, OTHER_BITS, 32'h0);
    i_host.select(1'b0);
    i_host.shift({24'h0, 3'b000, ADDR_POW}, 8, 1'b0, q);
    i_host.shift(32'h1555, POW_BITS, 1'b0, q);
    rd_chk(ADDR_POW, POW_BITS, 32'h0);
    i_host.select(1'b1);
    i_host.shift({24'h0, 3'b000, ADDR_FTW}, 8, 1'b0, q);
    i_host.shift(32'h0, 10, 1'b0, q);
    i_host.abort_now();
    wr(ADDR_POW, 32'h0abc, POW_BITS);
    rd_chk(ADDR_POW, POW_BITS, 32'h0abc);
    rd_chk(ADDR_FTW, FTW_BITS, 32'h8c3a_51e9);
    end_sim();
  end
endmodule : dds_core_clock_config_tb
`default_nettype wire
